// [pkg/irq_mask_defs.svh]
`ifndef IRQ_MASK_DEFS_SVH
`define IRQ_MASK_DEFS_SVH

// register indices, byte address is four times the index
`define IDX_MASK_TWO 8'h9A
`define IDX_MASK_ZERO 8'hA8
`define IDX_MASK_ONE 8'hB8
`define IDX_PEND_LO 8'hC0
`define IDX_PEND_MID 8'hC1
`define IDX_PEND_HI 8'hC2
`define ADDR_OF(idx) {2'b00, idx, 2'b00}

// reset value and writable bits of the mask registers
`define MASK_RST 8'h00
`define MASK0_WR 8'hBF
`define MASK1_WR 8'h3F
`define MASK2_WR 8'h3F

// mask register zero fields
`define GLOBAL_IRQ_GATE 7
`define SLEEP_TMR_IRQ_EN 5
`define CIPHER_DONE_IRQ_EN 4
`define SERIAL1_RX_IRQ_EN 3
`define SERIAL0_RX_IRQ_EN 2
`define CONVERTER_DONE_IRQ_EN 1
`define RADIO_ERROR_IRQ_EN 0
// mask register one fields
`define PORT_ZERO_IRQ_EN 5
`define TIMER_FOUR_IRQ_EN 4
`define TIMER_THREE_IRQ_EN 3
`define TIMER_TWO_IRQ_EN 2
`define TIMER_ONE_IRQ_EN 1
`define DMA_DONE_IRQ_EN 0
// mask register two fields
`define WATCHDOG_IRQ_EN 5
`define PORT_ONE_IRQ_EN 4
`define SERIAL1_TX_IRQ_EN 3
`define SERIAL0_TX_IRQ_EN 2
`define PORT_TWO_USB_IRQ_EN 1
`define RADIO_GENERAL_IRQ_EN 0

// source numbers and vector layout
`define SRC_NUM 18
`define SRC_TIMER_THREE 5'h0B
`define SRC_TIMER_FOUR 5'h0C
`define SRC_RADIO_GENERAL 5'h10
`define SRC_WATCHDOG 5'h11
`define VEC_TIMER_THREE 8'h5B
`define VEC_TIMER_FOUR 8'h63
`define VEC_RADIO_GENERAL 8'h83
`define VEC_WATCHDOG 8'h8B
`define VEC_LOW 3'h3

`endif

// [pkg/irq_mask_pkg.sv]
package irq_mask_pkg;

  // source vector, one bit per interrupt number
  typedef logic [17:0] src_vec_t;

  // request presented to the core
  typedef struct packed {
    logic req;
    logic [4:0] num;
    logic [7:0] vector;
  } irq_ans_s;

endpackage : irq_mask_pkg

// [rtl/irq_mask_ctrl.sv]
// Chosen here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "irq_mask_defs.svh"

module irq_mask_ctrl (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [17:0] srcEvent,
  input wire logic ackTake,
  output irq_mask_pkg::irq_ans_s irqAns
);
  import irq_mask_pkg::*;

  logic [7:0] mask0_r;
  logic [7:0] mask1_r;
  logic [7:0] mask2_r;
  logic [7:0] mask0_nxt;
  logic [7:0] mask1_nxt;
  logic [7:0] mask2_nxt;
  src_vec_t pend_r;
  src_vec_t pend_nxt;
  src_vec_t enVec;
  src_vec_t enVec_nxt;
  src_vec_t hwClr;
  src_vec_t swClr;
  irq_ans_s irqAns_r;
  irq_ans_s irqAns_nxt;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic setupPh;
  logic doneWr;

  // maps the three mask registers onto per-source enables
  function automatic src_vec_t maskToEn(
    input logic [7:0] m0,
    input logic [7:0] m1,
    input logic [7:0] m2
  );
    src_vec_t e;
    e = '0;
    e[0] = m0[`RADIO_ERROR_IRQ_EN];
    e[1] = m0[`CONVERTER_DONE_IRQ_EN];
    e[2] = m0[`SERIAL0_RX_IRQ_EN];
    e[3] = m0[`SERIAL1_RX_IRQ_EN];
    e[4] = m0[`CIPHER_DONE_IRQ_EN];
    e[5] = m0[`SLEEP_TMR_IRQ_EN];
    e[6] = m2[`PORT_TWO_USB_IRQ_EN];
    e[7] = m2[`SERIAL0_TX_IRQ_EN];
    e[8] = m1[`DMA_DONE_IRQ_EN];
    e[9] = m1[`TIMER_ONE_IRQ_EN];
    e[10] = m1[`TIMER_TWO_IRQ_EN];
    e[11] = m1[`TIMER_THREE_IRQ_EN];
    e[12] = m1[`TIMER_FOUR_IRQ_EN];
    e[13] = m1[`PORT_ZERO_IRQ_EN];
    e[14] = m2[`SERIAL1_TX_IRQ_EN];
    e[15] = m2[`PORT_ONE_IRQ_EN];
    e[16] = m2[`RADIO_GENERAL_IRQ_EN];
    e[17] = m2[`WATCHDOG_IRQ_EN];
    // global gate closes every source at once
    if (!m0[`GLOBAL_IRQ_GATE]) begin
      e = '0;
    end
    return e;
  endfunction : maskToEn

  // lowest source number wins among the active ones
  function automatic logic [4:0] pickSrc(input src_vec_t v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = `SRC_NUM - 1; i >= 0; i--) begin
      if (v[i]) begin
        n = 5'(i);
      end
    end
    return n;
  endfunction : pickSrc

  // vector address is eight times the number plus three
  function automatic logic [7:0] vecOf(input logic [4:0] n);
    return {n, `VEC_LOW};
  endfunction : vecOf

  // address decode, shared by read and write paths
  function automatic logic addrHit(input logic [11:0] a);
    return (a == `ADDR_OF(`IDX_MASK_ZERO)) ||
           (a == `ADDR_OF(`IDX_MASK_ONE)) ||
           (a == `ADDR_OF(`IDX_MASK_TWO)) ||
           (a == `ADDR_OF(`IDX_PEND_LO)) ||
           (a == `ADDR_OF(`IDX_PEND_MID)) ||
           (a == `ADDR_OF(`IDX_PEND_HI));
  endfunction : addrHit

  // read data, upper bits always zero
  function automatic logic [31:0] readWord(
    input logic [11:0] a,
    input logic [7:0] m0,
    input logic [7:0] m1,
    input logic [7:0] m2,
    input src_vec_t p
  );
    logic [7:0] b;
    b = 8'h00;
    case (a)
      `ADDR_OF(`IDX_MASK_ZERO): b = m0;
      `ADDR_OF(`IDX_MASK_ONE): b = m1;
      `ADDR_OF(`IDX_MASK_TWO): b = m2;
      `ADDR_OF(`IDX_PEND_LO): b = p[7:0];
      `ADDR_OF(`IDX_PEND_MID): b = p[15:8];
      `ADDR_OF(`IDX_PEND_HI): b = {6'h00, p[17:16]};
      default: b = 8'h00;
    endcase
    return {24'h000000, b};
  endfunction : readWord

  // apb phases: setup takes the decode, access completes a cycle later
  assign setupPh = psel & ~penable;
  assign doneWr = psel & penable & pready_r & pwrite & addrHit(paddr);

  // mask writes keep reserved bits at zero
  always_comb begin
    mask0_nxt = mask0_r;
    mask1_nxt = mask1_r;
    mask2_nxt = mask2_r;
    if (doneWr && paddr == `ADDR_OF(`IDX_MASK_ZERO)) begin
      mask0_nxt = pwdata[7:0] & `MASK0_WR;
    end
    if (doneWr && paddr == `ADDR_OF(`IDX_MASK_ONE)) begin
      mask1_nxt = pwdata[7:0] & `MASK1_WR;
    end
    if (doneWr && paddr == `ADDR_OF(`IDX_MASK_TWO)) begin
      mask2_nxt = pwdata[7:0] & `MASK2_WR;
    end
  end

  // software clears pending flags by writing ones
  always_comb begin
    swClr = '0;
    if (doneWr && paddr == `ADDR_OF(`IDX_PEND_LO)) begin
      swClr[7:0] = pwdata[7:0];
    end
    if (doneWr && paddr == `ADDR_OF(`IDX_PEND_MID)) begin
      swClr[15:8] = pwdata[7:0];
    end
    if (doneWr && paddr == `ADDR_OF(`IDX_PEND_HI)) begin
      swClr[17:16] = pwdata[1:0];
    end
  end

  // the core taking a vector clears that source's flag
  assign hwClr = (ackTake && irqAns_r.req) ? (18'h00001 << irqAns_r.num) : '0;

  // mask registers, all closed after reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask0_r <= `MASK_RST;
      mask1_r <= `MASK_RST;
      mask2_r <= `MASK_RST;
    end else if (clkEn) begin
      mask0_r <= mask0_nxt;
      mask1_r <= mask1_nxt;
      mask2_r <= mask2_nxt;
    end
  end

  // sticky pending flags; a new event beats any clear in the same cycle
  for (genvar g = 0; g < `SRC_NUM; g++) begin : gPend
    assign pend_nxt[g] = srcEvent[g] | (pend_r[g] & ~hwClr[g] & ~swClr[g]);
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        pend_r[g] <= 1'b0;
      end else if (clkEn) begin
        pend_r[g] <= pend_nxt[g];
      end
    end
  end

  assign enVec = maskToEn(mask0_r, mask1_r, mask2_r);
  assign enVec_nxt = maskToEn(mask0_nxt, mask1_nxt, mask2_nxt);

  // request built from next-state values so it tracks flags and masks exactly
  always_comb begin
    irqAns_nxt.req = |(pend_nxt & enVec_nxt);
    irqAns_nxt.num = pickSrc(pend_nxt & enVec_nxt);
    irqAns_nxt.vector = vecOf(irqAns_nxt.num);
  end

  // request register facing the core
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irqAns_r <= '0;
    end else if (clkEn) begin
      irqAns_r <= irqAns_nxt;
    end
  end

  // apb answer: ready in the first cycle of the access phase, no wait states
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (clkEn) begin
      pready_r <= setupPh;
      pslverr_r <= setupPh & ~addrHit(paddr);
    end
  end

  // read data captured at setup; unmapped addresses read zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h00000000;
    end else if (clkEn && setupPh) begin
      prdata_r <= readWord(paddr, mask0_r, mask1_r, mask2_r, pend_r);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irqAns = irqAns_r;

  // checks on the design's own registers and outputs
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // no request while the gate is shut
  property p_gate_shut;
    !mask0_r[`GLOBAL_IRQ_GATE] |-> !irqAns_r.req;
  endproperty
  a_gate_shut: assert property (p_gate_shut) else $error("request with gate shut");

  // a request names a pending and enabled source
  property p_own_enable;
    irqAns_r.req |-> (pend_r[irqAns_r.num] && enVec[irqAns_r.num]);
  endproperty
  a_own_enable: assert property (p_own_enable) else $error("request not enabled");

  // timer three vector
  property p_vec_t3;
    irqAns_r.req && irqAns_r.num == `SRC_TIMER_THREE |-> irqAns_r.vector == `VEC_TIMER_THREE;
  endproperty
  a_vec_t3: assert property (p_vec_t3) else $error("timer three vector wrong");

  // timer four vector
  property p_vec_t4;
    irqAns_r.req && irqAns_r.num == `SRC_TIMER_FOUR |-> irqAns_r.vector == `VEC_TIMER_FOUR;
  endproperty
  a_vec_t4: assert property (p_vec_t4) else $error("timer four vector wrong");

  // radio general vector
  property p_vec_rf;
    irqAns_r.req && irqAns_r.num == `SRC_RADIO_GENERAL |-> irqAns_r.vector == `VEC_RADIO_GENERAL;
  endproperty
  a_vec_rf: assert property (p_vec_rf) else $error("radio vector wrong");

  // watchdog vector
  property p_vec_wd;
    irqAns_r.req && irqAns_r.num == `SRC_WATCHDOG |-> irqAns_r.vector == `VEC_WATCHDOG;
  endproperty
  a_vec_wd: assert property (p_vec_wd) else $error("watchdog vector wrong");

  // events taken while clkEn is high leave their flag set
  property p_sticky;
    clkEn |=> ((pend_r & $past(srcEvent)) == $past(srcEvent));
  endproperty
  a_sticky: assert property (p_sticky) else $error("event lost");

  // an enabled event is requested on the next cycle
  property p_next_req;
    clkEn && (|(srcEvent & enVec_nxt)) |=> irqAns_r.req;
  endproperty
  a_next_req: assert property (p_next_req) else $error("enabled event not requested");

  // reserved bits stay zero
  property p_reserved;
    mask0_r[6] == 1'b0 && mask1_r[7:6] == 2'b00 && mask2_r[7:6] == 2'b00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  // a mask zero write lands on the next cycle
  property p_wr_mask0;
    clkEn && doneWr && paddr == `ADDR_OF(`IDX_MASK_ZERO) |=> mask0_r == ($past(pwdata[7:0]) & `MASK0_WR);
  endproperty
  a_wr_mask0: assert property (p_wr_mask0) else $error("mask zero write lost");

  // a mask one write lands on the next cycle
  property p_wr_mask1;
    clkEn && doneWr && paddr == `ADDR_OF(`IDX_MASK_ONE) |=> mask1_r == ($past(pwdata[7:0]) & `MASK1_WR);
  endproperty
  a_wr_mask1: assert property (p_wr_mask1) else $error("mask one write lost");

  // a mask two write lands on the next cycle
  property p_wr_mask2;
    clkEn && doneWr && paddr == `ADDR_OF(`IDX_MASK_TWO) |=> mask2_r == ($past(pwdata[7:0]) & `MASK2_WR);
  endproperty
  a_wr_mask2: assert property (p_wr_mask2) else $error("mask two write lost");

endmodule : irq_mask_ctrl
`default_nettype wire

// [verif/irq_src_model.sv]
`timescale 1ns/10ps
`default_nettype none
// peripherals raising events and the core taking vectors
module irq_src_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [17:0] evReq,
  input wire logic ackReq,
  input wire irq_mask_pkg::irq_ans_s irqAns,
  output logic [17:0] srcEvent,
  output logic ackTake
);
  import irq_mask_pkg::*;
  // events launch a cycle after the ask, blind to any mask
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) srcEvent <= '0;
    else srcEvent <= evReq;
  end
  // the core only takes a standing request, so a stray ack never clears a flag
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) ackTake <= 1'b0;
    else ackTake <= ackReq & irqAns.req;
  end
endmodule : irq_src_model
`default_nettype wire

// [verif/cpu_interrupt_enable_mask_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "irq_mask_defs.svh"
module cpu_interrupt_enable_mask_tb;
  import irq_mask_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [17:0] srcEvent;
  logic [17:0] evReq = '0;
  logic ackTake;
  logic ackReq = 1'b0;
  irq_ans_s irqAns;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int n_checks = 0;
  localparam logic [7:0] MREG [3] = '{`IDX_MASK_ZERO, `IDX_MASK_ONE, `IDX_MASK_TWO};
  localparam logic [7:0] PREG [3] = '{`IDX_PEND_LO, `IDX_PEND_MID, `IDX_PEND_HI};
  localparam logic [7:0] MWR [3] = '{8'hBF, 8'h3F, 8'h3F};
  // which mask register and bit gate each source number
  localparam int LOC_REG [18] = '{0, 0, 0, 0, 0, 0, 2, 2, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2};
  localparam int LOC_BIT [18] = '{0, 1, 2, 3, 4, 5, 1, 2, 0, 1, 2, 3, 4, 5, 3, 4, 0, 5};
  // vector address of each source number, kept as a table, not recomputed
  localparam logic [7:0] VEC [18] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h33, 8'h3B, 8'h43, 8'h4B,
    8'h53, `VEC_TIMER_THREE, `VEC_TIMER_FOUR, 8'h6B, 8'h73, 8'h7B, `VEC_RADIO_GENERAL, `VEC_WATCHDOG};

  always #20 clk_sys = ~clk_sys;

  irq_mask_ctrl i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .srcEvent(srcEvent), .ackTake(ackTake), .irqAns(irqAns));
  irq_src_model i_src (.clk_sys(clk_sys), .rst_n(rst_n), .evReq(evReq), .ackReq(ackReq), .irqAns(irqAns),
    .srcEvent(srcEvent), .ackTake(ackTake));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // one apb transfer, bounded wait so a dead slave ends the run
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= `ADDR_OF(idx);
    pwdata <= {24'h0, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic setm(input logic [7:0] m0, input logic [7:0] m1, input logic [7:0] m2);
    apb(1'b1, MREG[0], m0);
    apb(1'b1, MREG[1], m1);
    apb(1'b1, MREG[2], m2);
  endtask : setm

  // pending flags are write-one-to-clear
  task automatic clr();
    for (int j = 0; j < 3; j++) apb(1'b1, PREG[j], 8'hFF);
  endtask : clr

  // model launches the event one edge on, flag and request land on the next; returns on an edge
  task automatic fire(input logic [17:0] ev);
    evReq <= ev;
    @(posedge clk_sys);
    evReq <= '0;
    repeat (2) @(posedge clk_sys);
  endtask : fire

  initial begin
    logic [7:0] m [3];
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    // reset values, then reserved bits stay 0 through an all-ones write
    for (int j = 0; j < 3; j++) begin
      apb(1'b0, MREG[j], 8'h00);
      chk(rd, 32'h0);
      apb(1'b1, MREG[j], 8'hFF);
      apb(1'b0, MREG[j], 8'h00);
      chk(rd, {24'h0, MWR[j]});
    end
    apb(1'b0, 8'h10, 8'h00);
    chk({rd[7:0], err}, 9'h001);
    // gate closed: flags still set, nothing requested
    setm(8'h3F, 8'h3F, 8'h3F);
    fire('1);
    chk(irqAns.req, 1'b0);
    apb(1'b0, PREG[0], 8'h00);
    chk(rd, 32'hFF);
    apb(1'b0, PREG[2], 8'h00);
    chk(rd, 32'h03);
    apb(1'b1, MREG[0], 8'hBF);
    chk(irqAns, {1'b1, 5'h00, 8'h03});
    clr();
    chk(irqAns.req, 1'b0);
    // gate open but every own enable off
    setm(8'h80, 8'h00, 8'h00);
    fire('1);
    chk(irqAns.req, 1'b0);
    clr();
    // clock enable low freezes the flags, so an event then leaves no trace
    clkEn <= 1'b0;
    fire(18'h1);
    clkEn <= 1'b1;
    apb(1'b0, PREG[0], 8'h00);
    chk(rd, 32'h0);
    // each source alone: others stay quiet, its own number and vector come up, ack clears it
    for (int n = 0; n < 18; n++) begin
      for (int j = 0; j < 3; j++) m[j] = (j == 0) ? 8'h80 : 8'h00;
      m[LOC_REG[n]] = m[LOC_REG[n]] | (8'h01 << LOC_BIT[n]);
      setm(m[0], m[1], m[2]);
      fire(~(18'h1 << n));
      chk(irqAns.req, 1'b0);
      fire(18'h1 << n);
      chk(irqAns, {1'b1, 5'(n), VEC[n]});
      // ack leaves the model one edge on, clears the flag the next, seen after that
      ackReq <= 1'b1;
      @(posedge clk_sys);
      ackReq <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk(irqAns.req, 1'b0);
      clr();
    end
    stop_test();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    stop_test();
  end
endmodule : cpu_interrupt_enable_mask_tb
`default_nettype wire
